// file: rtl/mne_addr_resolve.sv
// Operand address resolution for byte-oriented file instructions.
`timescale 1ns/1ps
`default_nettype none
`include "mne_regs.svh"

module mne_addr_resolve (
	// Instruction fields.
	input wire logic access_sel,
	input wire logic [7:0] file_field,
	// Addressing context.
	input wire mne_pkg::mne_addr_ctx_type ctx,
	// Resolved data memory address.
	output logic [`MNE_ADDR_W-1:0] addr
);

	// Indexed mode takes priority over the access bank for low file values.
	always_comb begin
		if (access_sel) begin
			addr = {ctx.bank_select_register, file_field};
		end else if (ctx.ext_set_enable && file_field <= `MNE_IDX_MAX) begin
			// The index sum wraps inside the data space on purpose.
			addr = ctx.index_base
				+ {{(`MNE_ADDR_W-8){1'b0}}, file_field};
		end else if (file_field <= `MNE_ACC_LOW_TOP) begin
			addr = {`MNE_ACC_LOW_BANK, file_field};
		end else begin
			addr = {`MNE_ACC_HIGH_BANK, file_field};
		end
	end

endmodule : mne_addr_resolve
`default_nettype wire

// file: rtl/mne_execute.sv
// Execution datapath for the multiply-by-file and negate-file instructions.
//
// Summary of operation
// - Multiply forms the unsigned product of the accumulator and the file byte into product_high_byte and product_low_byte.
// - Multiply is decoded from opcode bits 0000 001, then the access bit and an 8-bit file field.
// - Multiply changes no status flag, not even for a zero product, and leaves the accumulator and file byte alone.
// - Negate replaces the file byte with its inverse plus one, written back to the same place.
// - Negate updates negative, signed range, carry, half carry and zero from its result.
// - Negate is decoded from opcode bits 0110 110, then the access bit and an 8-bit file field.
// - Access bit 0 selects the access bank; access bit 1 joins the bank select register with the file field.
// - With the extended set on, access bit 0 and file field up to 5Fh, indexed literal-offset addressing is used.
`timescale 1ns/1ps
`default_nettype none
`include "mne_regs.svh"

module mne_execute (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Instruction presented by the fetch stage.
	input wire logic [`MNE_WORD_W-1:0] instr_word,
	input wire logic instr_valid,
	// Core state read by the datapath.
	input wire logic [7:0] accumulator,
	input wire mne_pkg::mne_addr_ctx_type addr_ctx,
	// Data memory port.
	input wire logic [7:0] mem_rd_data,
	output logic [`MNE_ADDR_W-1:0] mem_addr_ff,
	output logic mem_rd_en_ff,
	output logic mem_wr_en_ff,
	output logic [7:0] mem_wr_data_ff,
	// Product register pair.
	output mne_pkg::mne_product_type product_ff,
	output logic product_wr_ff,
	// Status flags.
	output mne_pkg::mne_status_type status_ff,
	output logic status_wr_ff,
	// Cycle timing.
	output mne_pkg::mne_phase_type phase_ff,
	output logic done_ff
);

	// Matches an instruction word against a seven-bit opcode pattern.
	function automatic logic opc_match(
		input logic [`MNE_WORD_W-1:0] word,
		input logic [6:0] pattern
	);
		opc_match = (word[`MNE_OPC_MSB:`MNE_OPC_LSB] == pattern);
	endfunction : opc_match

	mne_pkg::mne_op_type op_ff;
	mne_pkg::mne_op_type nxt_op;
	mne_pkg::mne_phase_type nxt_phase;
	logic [7:0] acc_ff;
	logic [7:0] operand_ff;
	logic [`MNE_ADDR_W-1:0] resolved_addr;
	logic [15:0] nxt_product;
	logic [8:0] neg_sum;
	logic [4:0] neg_low_sum;
	mne_pkg::mne_status_type nxt_status;

	// Free-running quarter phase counter; one clock is one quarter.
	always_comb begin
		case (phase_ff)
			mne_pkg::PH_Q1: nxt_phase = mne_pkg::PH_Q2;
			mne_pkg::PH_Q2: nxt_phase = mne_pkg::PH_Q3;
			mne_pkg::PH_Q3: nxt_phase = mne_pkg::PH_Q4;
			mne_pkg::PH_Q4: nxt_phase = mne_pkg::PH_Q1;
			default: nxt_phase = mne_pkg::PH_Q1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_ff <= mne_pkg::PH_Q1;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	// Decode: only a valid word in Q1 starts an instruction.
	// Other opcodes decode to no operation and leave all outputs quiet.
	always_comb begin
		nxt_op = mne_pkg::OP_NONE;
		if (instr_valid) begin
			if (opc_match(instr_word, `MNE_OPC_MUL)) begin
				nxt_op = mne_pkg::OP_MUL;
			end else if (opc_match(instr_word, `MNE_OPC_NEG)) begin
				nxt_op = mne_pkg::OP_NEG;
			end
		end
	end

	// The operation is held for the whole cycle so later quarters agree.
	always_ff @(posedge clk) begin
		if (rst) begin
			op_ff <= mne_pkg::OP_NONE;
		end else if (phase_ff == mne_pkg::PH_Q1) begin
			op_ff <= nxt_op;
		end
	end

	// Address resolution uses the context as it stands at decode.
	mne_addr_resolve u_addr (
		.access_sel(instr_word[`MNE_ACC_BIT]),
		.file_field(instr_word[`MNE_FILE_MSB:`MNE_FILE_LSB]),
		.ctx(addr_ctx),
		.addr(resolved_addr)
	);

	// The address is latched at decode and held through write-back,
	// so the negate writes exactly where it read.
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr_ff <= `MNE_ADDR_ZERO;
		end else if (phase_ff == mne_pkg::PH_Q1 &&
				nxt_op != mne_pkg::OP_NONE) begin
			mem_addr_ff <= resolved_addr;
		end
	end

	// Read strobe stands for the Q2 quarter only.
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_rd_en_ff <= 1'b0;
		end else begin
			mem_rd_en_ff <= (phase_ff == mne_pkg::PH_Q1) &&
				(nxt_op != mne_pkg::OP_NONE);
		end
	end

	// Operand and accumulator are captured at the end of Q2.
	// Memory read data must be valid in the same Q2 clock.
	always_ff @(posedge clk) begin
		if (rst) begin
			operand_ff <= `MNE_BYTE_ZERO;
			acc_ff <= `MNE_BYTE_ZERO;
		end else if (phase_ff == mne_pkg::PH_Q2 && mem_rd_en_ff) begin
			operand_ff <= mem_rd_data;
			acc_ff <= accumulator;
		end
	end

	// Process quarter arithmetic; the accumulator is only ever read here.
	always_comb begin
		nxt_product = 16'(acc_ff) * 16'(operand_ff);
		neg_sum = {1'b0, ~operand_ff} + `MNE_NEG_ONE;
		neg_low_sum = {1'b0, ~operand_ff[3:0]} + 5'(`MNE_NEG_ONE);
		nxt_status.negative = neg_sum[7];
		nxt_status.signed_range_flag = (operand_ff == `MNE_SIGN_MIN);
		nxt_status.zero = (neg_sum[7:0] == `MNE_BYTE_ZERO);
		nxt_status.half_carry_flag = neg_low_sum[4];
		nxt_status.carry = neg_sum[8];
	end

	// Product pair loads at the end of Q3, so it is new during Q4.
	// A zero product still loads; nothing flags it.
	always_ff @(posedge clk) begin
		if (rst) begin
			product_ff <= '0;
		end else if (phase_ff == mne_pkg::PH_Q3 &&
				op_ff == mne_pkg::OP_MUL) begin
			product_ff <= nxt_product;
		end
	end

	// Product write strobe marks the Q4 quarter of a multiply.
	always_ff @(posedge clk) begin
		if (rst) begin
			product_wr_ff <= 1'b0;
		end else begin
			product_wr_ff <= (phase_ff == mne_pkg::PH_Q3) &&
				(op_ff == mne_pkg::OP_MUL);
		end
	end

	// Negate writes back to the same location during Q4.
	// The multiply never raises this strobe, so its source byte is safe.
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_wr_en_ff <= 1'b0;
			mem_wr_data_ff <= `MNE_BYTE_ZERO;
		end else if (phase_ff == mne_pkg::PH_Q3 &&
				op_ff == mne_pkg::OP_NEG) begin
			mem_wr_en_ff <= 1'b1;
			mem_wr_data_ff <= neg_sum[7:0];
		end else begin
			mem_wr_en_ff <= 1'b0;
		end
	end

	// Status flags change only for a negate; a multiply leaves them.
	always_ff @(posedge clk) begin
		if (rst) begin
			status_ff <= '0;
		end else if (phase_ff == mne_pkg::PH_Q3 &&
				op_ff == mne_pkg::OP_NEG) begin
			status_ff <= nxt_status;
		end
	end

	// Status write strobe tells the core to merge status_ff in Q4.
	always_ff @(posedge clk) begin
		if (rst) begin
			status_wr_ff <= 1'b0;
		end else begin
			status_wr_ff <= (phase_ff == mne_pkg::PH_Q3) &&
				(op_ff == mne_pkg::OP_NEG);
		end
	end

	// Completion pulse in Q4 of any executed instruction.
	always_ff @(posedge clk) begin
		if (rst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= (phase_ff == mne_pkg::PH_Q3) &&
				(op_ff != mne_pkg::OP_NONE);
		end
	end

endmodule : mne_execute
`default_nettype wire

// file: rtl/mne_pkg.sv
// Types shared by the multiply and negate execution datapath.
package mne_pkg;

	// Quarter phases of one instruction cycle.
	typedef enum logic [1:0] {
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4
	} mne_phase_type;

	// Operation latched at decode.
	typedef enum logic [1:0] {
		OP_NONE,
		OP_MUL,
		OP_NEG
	} mne_op_type;

	// Arithmetic status flags touched by the negate.
	typedef struct packed {
		logic negative;
		logic signed_range_flag;
		logic zero;
		logic half_carry_flag;
		logic carry;
	} mne_status_type;

	// Product register pair.
	typedef struct packed {
		logic [7:0] product_high_byte;
		logic [7:0] product_low_byte;
	} mne_product_type;

	// Addressing context supplied by the core.
	typedef struct packed {
		logic ext_set_enable;
		logic [3:0] bank_select_register;
		logic [11:0] index_base;
	} mne_addr_ctx_type;

endpackage : mne_pkg

// file: rtl/mne_regs.svh
// Named constants for the multiply and negate execution datapath.
`ifndef MNE_EXEC_REGS_SVH
`define MNE_EXEC_REGS_SVH

// Instruction word layout.
`define MNE_WORD_W 16
`define MNE_OPC_MSB 15
`define MNE_OPC_LSB 9
`define MNE_ACC_BIT 8
`define MNE_FILE_MSB 7
`define MNE_FILE_LSB 0

// Seven-bit opcode patterns in word bits 15..9.
`define MNE_OPC_MUL 7'h01
`define MNE_OPC_NEG 7'h36

// Data memory addressing.
`define MNE_ADDR_W 12
`define MNE_BANK_W 4
`define MNE_IDX_MAX 8'h5f
`define MNE_ACC_LOW_TOP 8'h5f
`define MNE_ACC_LOW_BANK 4'h0
`define MNE_ACC_HIGH_BANK 4'hf

// Reset values and negation constants.
`define MNE_BYTE_ZERO 8'h00
`define MNE_ADDR_ZERO 12'h000
`define MNE_NIB_ZERO 4'h0
`define MNE_SIGN_MIN 8'h80
`define MNE_NEG_ONE 9'h001

`endif

// file: verification/mne_execute_assertions.sv
// Port-level checks of the multiply and negate execution datapath.
`timescale 1ns/1ps
`default_nettype none
`include "mne_regs.svh"
module mne_execute_assertions (
	// Clock, reset and instruction side.
	input wire logic clk,
	input wire logic rst,
	input wire logic [`MNE_WORD_W-1:0] instr_word,
	input wire logic instr_valid,
	input wire logic [7:0] accumulator,
	input wire mne_pkg::mne_addr_ctx_type addr_ctx,
	input wire logic [7:0] mem_rd_data,
	// Outputs under watch.
	input wire logic [`MNE_ADDR_W-1:0] mem_addr_ff,
	input wire logic mem_rd_en_ff,
	input wire logic mem_wr_en_ff,
	input wire logic [7:0] mem_wr_data_ff,
	input wire mne_pkg::mne_product_type product_ff,
	input wire logic product_wr_ff,
	input wire mne_pkg::mne_status_type status_ff,
	input wire logic status_wr_ff,
	input wire mne_pkg::mne_phase_type phase_ff,
	input wire logic done_ff
);
	// Decode as the checker sees it; words outside a first quarter are noise.
	logic q1, t_mul, t_neg;
	logic [11:0] bank_addr;
	logic [11:0] idx_addr;
	logic [7:0] w;
	assign q1 = phase_ff == mne_pkg::PH_Q1;
	assign t_mul = q1 && instr_valid && instr_word[15:9] == `MNE_OPC_MUL;
	assign t_neg = q1 && instr_valid && instr_word[15:9] == `MNE_OPC_NEG;
	assign bank_addr = {addr_ctx.bank_select_register, instr_word[7:0]};
	// The index sum wraps inside the twelve-bit data space.
	assign idx_addr = addr_ctx.index_base + {4'h0, instr_word[7:0]};
	assign w = mem_wr_data_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_mul_seq; t_mul |=> mem_rd_en_ff ##2 product_wr_ff && done_ff && !status_wr_ff; endproperty
	a_mul_seq: assert property (p_mul_seq)
		else $error("multiply strobes out of step");
	property p_neg_seq; t_neg |=> mem_rd_en_ff ##2 mem_wr_en_ff && status_wr_ff && !product_wr_ff; endproperty
	a_neg_seq: assert property (p_neg_seq)
		else $error("negate strobes out of step");
	property p_idle; q1 && !t_mul && !t_neg |=> !mem_rd_en_ff ##2 !done_ff && !mem_wr_en_ff; endproperty
	a_idle: assert property (p_idle)
		else $error("ignored word produced activity");
	property p_prod; product_wr_ff |-> product_ff == $past(accumulator, 2) * $past(mem_rd_data, 2); endproperty
	a_prod: assert property (p_prod)
		else $error("product mismatch");
	property p_keep; product_wr_ff |-> $stable(status_ff) && !mem_wr_en_ff; endproperty
	a_keep: assert property (p_keep)
		else $error("multiply touched flags or memory");
	property p_neg_data; mem_wr_en_ff |-> w == 8'(~$past(mem_rd_data, 2) + 8'h01) && $stable(mem_addr_ff); endproperty
	a_neg_data: assert property (p_neg_data)
		else $error("negate write wrong");
	property p_flags; status_wr_ff |-> status_ff == {w[7], w == 8'h80, w == 8'h00, w[3:0] == 4'h0, w == 8'h00}; endproperty
	a_flags: assert property (p_flags)
		else $error("negate flags wrong");
	property p_bank; (t_mul || t_neg) && instr_word[8] |=> mem_addr_ff == $past(bank_addr); endproperty
	a_bank: assert property (p_bank)
		else $error("banked address wrong");
	property p_index;
		(t_mul || t_neg) && !instr_word[8] && addr_ctx.ext_set_enable &&
			instr_word[7:0] <= 8'h5f |=> mem_addr_ff == $past(idx_addr);
	endproperty
	a_index: assert property (p_index)
		else $error("indexed address wrong");
	property p_phase;
		q1 |=> phase_ff == mne_pkg::PH_Q2 ##1 phase_ff == mne_pkg::PH_Q3
			##1 phase_ff == mne_pkg::PH_Q4 ##1 q1;
	endproperty
	a_phase: assert property (p_phase)
		else $error("quarter phases out of order");
	c_mul: cover property (t_mul && instr_word[8]);
	c_neg: cover property (t_neg && !instr_word[8]);
	c_carry: cover property (status_wr_ff && status_ff.carry);
	c_index: cover property (t_neg && !instr_word[8] &&
		addr_ctx.ext_set_enable && instr_word[7:0] <= 8'h5f);
endmodule : mne_execute_assertions
bind mne_execute mne_execute_assertions chk_u (.clk, .rst, .instr_word,
	.instr_valid, .accumulator, .addr_ctx, .mem_rd_data, .mem_addr_ff,
	.mem_rd_en_ff, .mem_wr_en_ff, .mem_wr_data_ff, .product_ff, .product_wr_ff,
	.status_ff, .status_wr_ff, .phase_ff, .done_ff);
`default_nettype wire

// file: verification/mne_execute_bench.sv
// Self-checking bench for the multiply and negate execution datapath.
`timescale 1ns/1ps
`default_nettype none
module mne_execute_bench;
	logic clk = 0, rst = 1, instr_valid = 0, mem_rd_en_ff, mem_wr_en_ff;
	logic product_wr_ff, status_wr_ff, done_ff;
	logic [15:0] instr_word = 16'h0000;
	logic [7:0] accumulator = 8'h00, mem_rd_data = 8'h00, mem_wr_data_ff;
	logic [11:0] mem_addr_ff;
	mne_pkg::mne_addr_ctx_type addr_ctx = '0;
	mne_pkg::mne_product_type product_ff, prod_old;
	mne_pkg::mne_status_type status_ff, stat_old;
	mne_pkg::mne_phase_type phase_ff;
	int err_count = 0, tests_run = 0, cyc = 0, seed = 71, i;
	mne_execute dut_u (.clk, .rst, .instr_word, .instr_valid, .accumulator,
		.addr_ctx, .mem_rd_data, .mem_addr_ff, .mem_rd_en_ff, .mem_wr_en_ff,
		.mem_wr_data_ff, .product_ff, .product_wr_ff, .status_ff,
		.status_wr_ff, .phase_ff, .done_ff);
	// Half-period toggle gives the 200 MHz core clock.
	always #2.5 clk = ~clk;
	// Cycle ceiling so that a stuck phase counter cannot hang the run.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	function automatic logic [11:0] ea(input logic a, input logic [7:0] f);
		if (a) return {addr_ctx.bank_select_register, f};
		if (f > 8'h5f) return {4'hf, f};
		return addr_ctx.ext_set_enable ? addr_ctx.index_base + 12'(f) : 12'(f);
	endfunction : ea
	function automatic mne_pkg::mne_status_type flags(input logic [7:0] x);
		logic [7:0] r;
		r = 8'(~x + 8'h01);
		return '{r[7], x == 8'h80, r == 8'h00, x[3:0] == 4'h0, x == 8'h00};
	endfunction : flags
	// Kind 0 multiplies, 1 negates, 2 is a foreign opcode, 3 is not valid.
	task automatic op(input int k, input logic a, input logic [7:0] f, x, w,
			input logic [16:0] c);
		// Back to back: a held word must never be decoded a second time.
		while (phase_ff !== mne_pkg::PH_Q4) @(negedge clk);
		@(posedge clk);
		instr_valid <= k != 3;
		instr_word <= {k == 1 ? 7'h36 : k == 2 ? 7'h02 : 7'h01, a, f};
		addr_ctx <= c;
		prod_old = product_ff;
		stat_old = status_ff;
		@(posedge clk);
		accumulator <= w;
		mem_rd_data <= x;
		@(negedge clk);
		chk("rd_en", mem_rd_en_ff, 16'(k < 2));
		if (k < 2) chk("addr", mem_addr_ff, ea(a, f));
		@(posedge clk);
		// Stale read data would hide a late sample, so invert it.
		mem_rd_data <= ~x;
		@(posedge clk);
		@(negedge clk);
		chk("done", done_ff, 16'(k < 2));
		chk("prod", product_ff, k == 0 ? w * x : prod_old);
		chk("stat", status_ff, k == 1 ? flags(x) : stat_old);
		if (k == 1) chk("wdata", mem_wr_data_ff, 8'(~x + 8'h01));
		chk("wr", {mem_wr_en_ff, status_wr_ff, product_wr_ff},
			{k == 1, k == 1, k == 0});
	endtask : op
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done
	// Corner cases first, then a seeded random mix of all four kinds.
	initial begin
		repeat (6) @(posedge clk);
		rst <= 0;
		op(1, 0, 8'h5f, 8'h00, 8'h12, 17'h1_0123);
		op(1, 0, 8'h60, 8'h80, 8'h34, 17'h1_0123);
		op(0, 1, 8'hab, 8'hc4, 8'h00, 17'h0_5000);
		op(0, 0, 8'h00, 8'hff, 8'hff, 17'h0_0000);
		op(2, 1, 8'h10, 8'h3a, 8'h55, 17'h0_2000);
		op(3, 0, 8'h20, 8'h3a, 8'h55, 17'h0_0000);
		for (i = 0; i < 80; i++) begin
			op($unsigned($random(seed)) % 4, 1'($random(seed)),
				8'($random(seed)), 8'($random(seed)), 8'($random(seed)),
				17'($random(seed)));
		end
		test_done();
	end
endmodule : mne_execute_bench
`default_nettype wire
